/* pkg/atr_defines.svh */
`ifndef ATR_DEFINES_SVH
`define ATR_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define ATR_OFS_TURNS 8'h2C
`define ATR_OFS_HYST 8'h30
`define ATR_OFS_FINE 8'h32
`define ATR_OFS_LOWP 8'h34

// ****************************************
// Field positions and fixed values
// ****************************************
`define ATR_ID_TURNS 3'h6
`define ATR_BIT_FAULT 14
`define ATR_BIT_UV 13
`define ATR_BIT_PARITY 12
`define ATR_UNMAPPED_WORD 16'h0000

// ****************************************
// Reset values
// ****************************************
`define ATR_RST_WORD 16'h0000
`define ATR_RST_POS 12'h000
`define ATR_RST_OCTANT 3'h0

`endif

/* pkg/atr_pkg.sv */
package atr_pkg;

    typedef enum logic [1:0] {
        ATR_STEP_NONE = 2'h0,
        ATR_STEP_UP = 2'h1,
        ATR_STEP_DOWN = 2'h3
    } atr_step_type;

    typedef enum logic [1:0] {
        ATR_TRK_WAIT = 2'h0,
        ATR_TRK_RUN = 2'h1
    } atr_track_type;

endpackage

/* src/atr_sync.sv */
`timescale 1ns/1ns

// Three-stage synchroniser; output follows once stages two and three agree
module atr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (s2_r == s3_r) begin
            q_nxt = s3_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule // atr_sync

/* src/atr_regs.sv */
`timescale 1ns/1ns
`include "atr_defines.svh"

// Behaviour
// - Turns word carries identifier 110 in bits 15 to 13.
// - Bit 12 of turns, hysteresis and low-power words makes ones count odd.
// - Turns is 12-bit two's complement relative to power-up angle.
// - Turns step is half or eighth rotation per nonvolatile setting.
// - Counter tracks 256 full rotations either way in both modes.
// - Half mode spans -512..511; eighth mode spans -2048..2047.
// - Bit 14 of hysteresis and low-power words is OR of unmasked error and warning bits.
// - Bit 13 is masked OR of synchronised analog and real-time digital undervoltage.
// - Hysteresis word holds 12-bit hysteresis angle, bit 15 zero.
// - Fine word holds 15-bit compensated angle, bit 15 zero.
// - Turns count derives from zero-crossing angle path, both power modes.
// - Low-power word holds 12-bit zero-crossing angle, bit 15 zero.
// - Passing the 256-rotation limit latches overflow until turns reset.
module atr_regs #(
    parameter int ERR_W = 16,
    parameter int WARN_W = 16
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic LINK_CLK,
    input wire logic LINK_SEL_B,
    input wire logic LINK_WR,
    input wire logic [7:0] LINK_ADDR,
    input wire logic [ERR_W-1:0] ERR_FLAGS,
    input wire logic [ERR_W-1:0] ERR_MASK,
    input wire logic [WARN_W-1:0] WARN_FLAGS,
    input wire logic [WARN_W-1:0] WARN_MASK,
    input wire logic ANALOG_UNDERVOLTAGE,
    input wire logic DIGITAL_UNDERVOLTAGE,
    input wire logic ANALOG_UV_MASK,
    input wire logic DIGITAL_UV_MASK,
    input wire logic TURNS_STEP_EIGHTH,
    input wire logic [11:0] HYSTERESIS_ANGLE_VALUE,
    input wire logic [14:0] FINE_ANGLE_VALUE,
    input wire logic [11:0] ZERO_CROSSING_ANGLE_VALUE,
    input wire logic ZERO_CROSSING_VALID,
    input wire logic TURNS_RESET,
    output logic [15:0] RD_DATA,
    output logic RD_VALID,
    output logic ROTATION_COUNT_OVERFLOW
);
    // ****************************************
    // Reset release
    // ****************************************
    logic rst_s1_r;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_s1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n <= rst_s1_r;
        end
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [11:0] link_q;
    logic link_clk_s;
    logic link_sel_b_s;
    logic link_wr_s;
    logic [7:0] link_addr_s;
    logic uva_s;

    atr_sync #(.WIDTH(12)) u_link_sync (
        .clk(CLK),
        .rst_n(rst_n),
        .d({LINK_CLK, LINK_SEL_B, LINK_WR, ANALOG_UNDERVOLTAGE, LINK_ADDR}),
        .q(link_q)
    );

    assign link_clk_s = link_q[11];
    assign link_sel_b_s = link_q[10];
    assign link_wr_s = link_q[9];
    assign uva_s = link_q[8];
    assign link_addr_s = link_q[7:0];

    // ****************************************
    // Turns tracking on the zero-crossing path
    // ****************************************
    // Position is kept in eighths; half mode shows it shifted by two,
    // so both modes share one 256-rotation limit.
    atr_pkg::atr_track_type trk_r;
    atr_pkg::atr_track_type trk_nxt;
    atr_pkg::atr_step_type step;
    logic [2:0] oct_r;
    logic [2:0] oct_nxt;
    logic [2:0] oct_now;
    logic [2:0] oct_diff;
    logic signed [11:0] pos_r;
    logic signed [11:0] pos_nxt;
    logic tov_r;
    logic tov_nxt;
    logic ovf_hit;

    assign oct_now = ZERO_CROSSING_ANGLE_VALUE[11:9];
    assign oct_diff = oct_now - oct_r;
    // Overflow event; it beats a turns reset in the same cycle
    assign ovf_hit = ZERO_CROSSING_VALID && (trk_r == atr_pkg::ATR_TRK_RUN) &&
        (((oct_diff == 3'h1) && (pos_r == 12'sh7FF)) ||
        ((oct_diff == 3'h7) && (pos_r == -12'sh800)));

    always_comb begin
        trk_nxt = trk_r;
        oct_nxt = oct_r;
        pos_nxt = pos_r;
        tov_nxt = tov_r;
        step = atr_pkg::ATR_STEP_NONE;
        if (oct_diff == 3'h1) begin
            step = atr_pkg::ATR_STEP_UP;
        end else if (oct_diff == 3'h7) begin
            step = atr_pkg::ATR_STEP_DOWN;
        end
        if (TURNS_RESET) begin
            // Rebase on the next sample, clear count; overflow unless hit now
            trk_nxt = atr_pkg::ATR_TRK_WAIT;
            pos_nxt = `ATR_RST_POS;
            tov_nxt = ovf_hit;
        end else if (ZERO_CROSSING_VALID) begin
            case (trk_r)
                atr_pkg::ATR_TRK_WAIT: begin
                    oct_nxt = oct_now;
                    trk_nxt = atr_pkg::ATR_TRK_RUN;
                end
                atr_pkg::ATR_TRK_RUN: begin
                    oct_nxt = oct_now;
                    // Jumps past one octant are dropped; sample rate must keep up
                    case (step)
                        atr_pkg::ATR_STEP_UP: begin
                            if (pos_r == 12'sh7FF) begin
                                tov_nxt = 1'b1;
                            end else begin
                                pos_nxt = pos_r + 12'sh001;
                            end
                        end
                        atr_pkg::ATR_STEP_DOWN: begin
                            if (pos_r == -12'sh800) begin
                                tov_nxt = 1'b1;
                            end else begin
                                pos_nxt = pos_r - 12'sh001;
                            end
                        end
                        default: begin
                            pos_nxt = pos_r;
                        end
                    endcase
                end
                default: begin
                    trk_nxt = atr_pkg::ATR_TRK_WAIT;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            trk_r <= atr_pkg::ATR_TRK_WAIT;
            oct_r <= `ATR_RST_OCTANT;
            pos_r <= `ATR_RST_POS;
            tov_r <= 1'b0;
        end else begin
            trk_r <= trk_nxt;
            oct_r <= oct_nxt;
            pos_r <= pos_nxt;
            tov_r <= tov_nxt;
        end
    end

    // ****************************************
    // Word assembly
    // ****************************************
    logic [11:0] turns_val;
    logic fault_flag;
    logic uv_flag;
    logic [15:0] turns_word;
    logic [15:0] hyst_word;
    logic [15:0] fine_word;
    logic [15:0] lowp_word;
    logic [15:0] sel_word;

    // Half mode: arithmetic shift maps -2048..2047 onto -512..511
    assign turns_val = TURNS_STEP_EIGHTH ? pos_r : (pos_r >>> 2);
    assign fault_flag = (|(ERR_FLAGS & ~ERR_MASK)) | (|(WARN_FLAGS & ~WARN_MASK));
    assign uv_flag = (uva_s & ~ANALOG_UV_MASK) | (DIGITAL_UNDERVOLTAGE & ~DIGITAL_UV_MASK);

    assign turns_word = {`ATR_ID_TURNS, ~^{`ATR_ID_TURNS, turns_val}, turns_val};
    assign hyst_word = {1'b0, fault_flag, uv_flag,
        ~^{fault_flag, uv_flag, HYSTERESIS_ANGLE_VALUE}, HYSTERESIS_ANGLE_VALUE};
    assign fine_word = {1'b0, FINE_ANGLE_VALUE};
    assign lowp_word = {1'b0, fault_flag, uv_flag,
        ~^{fault_flag, uv_flag, ZERO_CROSSING_ANGLE_VALUE}, ZERO_CROSSING_ANGLE_VALUE};

    always_comb begin
        case (link_addr_s)
            `ATR_OFS_TURNS: sel_word = turns_word;
            `ATR_OFS_HYST: sel_word = hyst_word;
            `ATR_OFS_FINE: sel_word = fine_word;
            `ATR_OFS_LOWP: sel_word = lowp_word;
            default: sel_word = `ATR_UNMAPPED_WORD;
        endcase
    end

    // ****************************************
    // Link read port
    // ****************************************
    logic link_clk_d_r;
    logic link_rise;
    logic [15:0] rd_data_r;
    logic [15:0] rd_data_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;

    assign link_rise = link_clk_s & ~link_clk_d_r & ~link_sel_b_s;

    always_comb begin
        rd_data_nxt = rd_data_r;
        rd_valid_nxt = 1'b0;
        // Writes get no answer and touch nothing
        if (link_rise && !link_wr_s) begin
            rd_data_nxt = sel_word;
            rd_valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            link_clk_d_r <= 1'b0;
            rd_data_r <= `ATR_RST_WORD;
            rd_valid_r <= 1'b0;
        end else begin
            link_clk_d_r <= link_clk_s;
            rd_data_r <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
        end
    end

    assign RD_DATA = rd_data_r;
    assign RD_VALID = rd_valid_r;
    assign ROTATION_COUNT_OVERFLOW = tov_r;
endmodule // atr_regs

/* sim/atr_regs_assertions.sv */
`timescale 1ns/1ns
// ****
// Port checks
// ****
module atr_regs_checker (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic LINK_CLK,
    input wire logic LINK_SEL_B,
    input wire logic LINK_WR,
    input wire logic ZERO_CROSSING_VALID,
    input wire logic TURNS_RESET,
    input wire logic [15:0] RD_DATA,
    input wire logic RD_VALID,
    input wire logic ROTATION_COUNT_OVERFLOW
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    a_valid_one_cycle: assert property (RD_VALID |=> !RD_VALID)
        else $error("read strobe longer than one cycle");
    a_data_holds: assert property (!RD_VALID |-> $stable(RD_DATA))
        else $error("read word changed without a read");
    a_turns_parity: assert property (RD_VALID && RD_DATA[15:13] == 3'h6 |-> ^RD_DATA)
        else $error("turns word has even parity");
    a_read_answer: assert property ($rose(LINK_CLK) && !LINK_SEL_B && !LINK_WR
        |-> ##[3:7] RD_VALID) else $error("read not answered");
    a_refused_quiet: assert property ($rose(LINK_CLK) && (LINK_SEL_B || LINK_WR)
        |-> ##1 !RD_VALID [*8]) else $error("refused access answered");
    a_ovf_sticky: assert property (ROTATION_COUNT_OVERFLOW && !TURNS_RESET
        |=> ROTATION_COUNT_OVERFLOW) else $error("overflow dropped by itself");
    a_ovf_clear: assert property (TURNS_RESET && !ZERO_CROSSING_VALID
        |=> !ROTATION_COUNT_OVERFLOW)
        else $error("overflow not cleared");
    a_ovf_cause: assert property ($rose(ROTATION_COUNT_OVERFLOW) |->
        $past(ZERO_CROSSING_VALID) || $past(ZERO_CROSSING_VALID, 2) ||
        $past(ZERO_CROSSING_VALID, 3)) else $error("overflow without a sample");
endmodule // atr_regs_checker

bind atr_regs atr_regs_checker u_chk (.CLK(CLK), .RST_B(RST_B), .LINK_CLK(LINK_CLK),
    .LINK_SEL_B(LINK_SEL_B), .LINK_WR(LINK_WR), .ZERO_CROSSING_VALID(ZERO_CROSSING_VALID),
    .TURNS_RESET(TURNS_RESET), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
    .ROTATION_COUNT_OVERFLOW(ROTATION_COUNT_OVERFLOW));

/* sim/atr_host_model.sv */
`timescale 1ns/1ns
// ****
// Host reader on the sampled link pins
// ****
module atr_host_model (
    input wire logic clk,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    output logic link_clk,
    output logic sel_b,
    output logic wr,
    output logic [7:0] addr
);
    initial begin
        link_clk = 1'b0;
        sel_b = 1'b1;
        wr = 1'b0;
        addr = 8'h00;
    end
    // Link clock idles low; released address lines show the inverse, not old data
    task xfer(input logic [7:0] a, input logic w, input logic s,
              output logic [15:0] d, output logic ok);
        ok = 1'b0;
        d = 16'h0000;
        @(negedge clk);
        addr = a;
        wr = w;
        sel_b = s;
        repeat (4) @(negedge clk);
        link_clk = 1'b1;
        for (int i = 0; i < 8; i++) begin
            // Sampled mid-cycle, where the registered answer has settled
            @(negedge clk);
            if (rd_valid === 1'b1 && !ok) begin
                d = rd_data;
                ok = 1'b1;
            end
            if (i == 3)
                link_clk = 1'b0;
        end
        sel_b = 1'b1;
        wr = ~wr;
        addr = ~addr;
    endtask
endmodule // atr_host_model

/* sim/test_atr_regs.sv */
`timescale 1ns/1ns
module test_atr_regs;
    logic clk, rst_b, analog_undervoltage, digital_undervoltage, uvam, uvdm, eighth, zcv, trst, rd_valid, ovf;
    logic lclk, lsel_b, lwr, ok;
    logic [15:0] ef, em, wf, wm, rd_data, d;
    logic [11:0] hysteresis_angle, low_power_angle_word;
    logic [14:0] fang;
    logic [7:0] laddr;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    atr_regs dut (.CLK(clk), .RST_B(rst_b), .LINK_CLK(lclk), .LINK_SEL_B(lsel_b),
        .LINK_WR(lwr), .LINK_ADDR(laddr), .ERR_FLAGS(ef), .ERR_MASK(em), .WARN_FLAGS(wf),
        .WARN_MASK(wm), .ANALOG_UNDERVOLTAGE(analog_undervoltage), .DIGITAL_UNDERVOLTAGE(digital_undervoltage),
        .ANALOG_UV_MASK(uvam), .DIGITAL_UV_MASK(uvdm), .TURNS_STEP_EIGHTH(eighth),
        .HYSTERESIS_ANGLE_VALUE(hysteresis_angle), .FINE_ANGLE_VALUE(fang),
        .ZERO_CROSSING_ANGLE_VALUE(low_power_angle_word), .ZERO_CROSSING_VALID(zcv), .TURNS_RESET(trst),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .ROTATION_COUNT_OVERFLOW(ovf));
    atr_host_model host (.clk(clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .link_clk(lclk), .sel_b(lsel_b), .wr(lwr), .addr(laddr));
    // ****
    // Helpers
    // ****
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fails++;
            end_sim();
        end
    end
    function automatic logic [15:0] aw(input logic f, u, input logic [11:0] a);
        return {1'b0, f, u, ~^{f, u, a}, a};
    endfunction
    function automatic logic [15:0] tw(input logic [11:0] t);
        return {3'h6, ~^{3'h6, t}, t};
    endfunction
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task rd(input logic [7:0] a, input logic [15:0] e, input string n);
        host.xfer(a, 1'b0, 1'b0, d, ok);
        chk({n, " valid"}, 16'h0001, {15'h0000, ok});
        chk(n, e, d);
    endtask
    task step(input logic [2:0] o);
        @(negedge clk);
        low_power_angle_word = {o, 9'h000};
        zcv = 1'b1;
        @(negedge clk);
        zcv = 1'b0;
    endtask
    task pulse_reset();
        @(negedge clk);
        trst = 1'b1;
        @(negedge clk);
        trst = 1'b0;
    endtask
    task end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task t_angles();
        rd(8'h30, aw(1'b0, 1'b0, hysteresis_angle), "hyst");
        rd(8'h32, {1'b0, fang}, "fine");
        rd(8'h34, aw(1'b0, 1'b0, low_power_angle_word), "lowp");
    endtask
    task t_flags();
        ef = 16'h0100;
        em = 16'h0100;
        rd(8'h30, aw(1'b0, 1'b0, hysteresis_angle), "err masked");
        em = 16'h0000;
        rd(8'h34, aw(1'b1, 1'b0, low_power_angle_word), "err");
        ef = 16'h0000;
        wf = 16'h8000;
        rd(8'h30, aw(1'b1, 1'b0, hysteresis_angle), "warn");
        wm = 16'h8000;
        digital_undervoltage = 1'b1;
        rd(8'h34, aw(1'b0, 1'b1, low_power_angle_word), "uv dig");
        uvdm = 1'b1;
        analog_undervoltage = 1'b1;
        rd(8'h30, aw(1'b0, 1'b1, hysteresis_angle), "uv ana");
        uvam = 1'b1;
        rd(8'h34, aw(1'b0, 1'b0, low_power_angle_word), "uv masked");
    endtask
    task t_turns();
        pulse_reset();
        step(3'h0);
        for (int i = 1; i < 4; i++)
            step(i[2:0]);
        hysteresis_angle = 12'h000;
        rd(8'h2C, tw(12'h003), "turns up");
        for (int i = 10; i > 4; i--)
            step(i[2:0]);
        rd(8'h2C, tw(12'hFFD), "turns down");
        eighth = 1'b0;
        rd(8'h2C, tw(12'hFFF), "half down");
    endtask
    task t_ovf();
        eighth = 1'b1;
        pulse_reset();
        step(3'h0);
        for (int i = 1; i < 2048; i++)
            step(i[2:0]);
        rd(8'h2C, tw(12'h7FF), "eighth top");
        chk("ovf clear", 16'h0000, {15'h0000, ovf});
        eighth = 1'b0;
        rd(8'h2C, tw(12'h1FF), "half top");
        step(3'h0);
        repeat (3) @(negedge clk);
        chk("ovf set", 16'h0001, {15'h0000, ovf});
        pulse_reset();
        chk("ovf reset", 16'h0000, {15'h0000, ovf});
        rd(8'h2C, tw(12'h000), "turns reset");
        step(3'h0);
        for (int i = 1; i < 2049; i++)
            step(3'h0 - i[2:0]);
        rd(8'h2C, tw(12'hE00), "half bottom");
        chk("ovf low clear", 16'h0000, {15'h0000, ovf});
        step(3'h7);
        repeat (3) @(negedge clk);
        chk("ovf low set", 16'h0001, {15'h0000, ovf});
        eighth = 1'b1;
        rd(8'h2C, tw(12'h800), "eighth floor");
    endtask
    task t_refuse();
        host.xfer(8'h30, 1'b1, 1'b0, d, ok);
        chk("write answer", 16'h0000, {15'h0000, ok});
        host.xfer(8'h34, 1'b0, 1'b1, d, ok);
        chk("deselected", 16'h0000, {15'h0000, ok});
        chk("word kept", tw(12'h800), rd_data);
        rd(8'h2E, 16'h0000, "unmapped");
    endtask
    initial begin
        {ef, em, wf, wm} = '0;
        {analog_undervoltage, digital_undervoltage, uvam, uvdm, zcv, trst} = '0;
        eighth = 1'b1;
        hysteresis_angle = 12'hABC;
        fang = 15'h5A5A;
        low_power_angle_word = 12'h123;
        rst_b = 1'b0;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        t_angles();
        t_flags();
        t_turns();
        t_ovf();
        t_refuse();
        end_sim();
    end
endmodule // test_atr_regs
